//--- rtl/dfm_top.sv
// drivetrain fault monitor: self-test, fault filters, codes, link
`timescale 1ns/1ps
// Operation
// - memory test at ignition, retest, lamp dark
// - then calibration memory test, lamp, defaults
// - no code recording with calibration memory fault
// - calibration memory fault held until ignition cycle
// - motor/encoder fault confirmed after one second
// - motor off: line grounded or open circuit
// - motor on: grounded, lines shorted, or open
// - encoder invalid code or line grounded
// - confirmed fault idle: ignore shift commands
// - pending shift discarded on confirmed fault
// - invalid code mid-shift: drive toward high
// - non-energized fault recovers after one second
// - energized motor fault latched until ignition
// - one speed sensor: lamp, other sensor
// - speed fault in low range forces duty
// - speed fault blocks new shifts until ignition
// - speed fault recovers after half second
// - both sensors: touch-off at zero speed
// - coil fault 0.8 s: lamp, stop torque
// - coil fault recovers after 0.8 s
// - first fault writes a persistent trouble code
// - tester reads codes over the serial link
// - maximum degraded duty is eighty-eight percent
module dfm_top
  import dfm_pkg::*;
#(
  parameter int TICK_CYC = TICK_NS / CLK_NS,
  parameter int BIT_CYC  = CLK_HZ / KLINE_BD
) (
  // clock and ignition reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // memory self-test handshake
  input  wire logic        mem_done_i,
  input  wire logic        mem_pass_i,
  input  wire logic        nvm_done_i,
  input  wire logic        nvm_pass_i,
  input  wire logic [4:0]  nvm_codes_i,
  output logic             mem_test_o,
  output logic             nvm_test_o,
  output logic             core_reset_o,
  output logic             func_en_o,
  output logic             default_cal_o,
  // code store write port
  output logic             nvm_wr_o,
  output logic      [4:0]  nvm_wdata_o,
  // sensed faults
  input  wire logic        motor_on_i,
  input  wire logic        motor_hl_gnd_i,
  input  wire logic        motor_lh_gnd_i,
  input  wire logic        motor_lines_i,
  input  wire logic        motor_open_i,
  input  wire logic [3:0]  enc_code_i,
  input  wire logic [3:0]  enc_gnd_i,
  input  wire logic        front_flt_i,
  input  wire logic        rear_flt_i,
  input  wire logic        coil_open_i,
  input  wire logic        coil_gnd_i,
  // shift state and range
  input  wire logic        low_range_i,
  input  wire logic        shift_pend_i,
  input  wire logic        shift_busy_i,
  // degraded-mode controls
  output logic             drive_fault_lamp_o,
  output logic             shift_allow_o,
  output logic             shift_cancel_o,
  output logic             drive_high_o,
  output logic      [1:0]  touch_sel_o,
  output logic             slip_off_o,
  output logic             duty_force_o,
  output logic      [6:0]  duty_max_o,
  output logic             torque_stop_o,
  // diagnostic k-line, open drain
  input  wire logic        kline_i,
  output logic             kline_o,
  output logic             kline_oe_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // limit of a channel's filter in ms
  function automatic logic [MS_W-1:0] lim_of(input int ch);
    if (ch == CH_COIL) lim_of = COIL_MS;
    else if (ch >= CH_FRNT) lim_of = SPEED_MS;
    else lim_of = MOTOR_MS;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // time base: 1 ms enable pulse
  logic [16:0] tick_cnt_q, tick_cnt_d;  // divider count
  logic        tick_q, tick_d;          // one-cycle tick

  always_comb
  begin
    tick_d     = (tick_cnt_q == 17'(TICK_CYC - 1));
    tick_cnt_d = tick_d ? 17'd0 : tick_cnt_q + 17'd1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt_q <= 17'd0;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // power-up self-test sequencer
  dfm_st_e st_q, st_d;     // sequencer state
  logic    nvm_flt_q, nvm_flt_d;  // calibration memory fault

  always_comb
  begin
    st_d      = st_q;
    nvm_flt_d = nvm_flt_q;
    case (st_q)
      ST_MEM:
      begin
        if (mem_done_i)
          st_d = mem_pass_i ? ST_NVM : ST_RST;
      end
      ST_RST: st_d = ST_MEM;   // one-cycle core reset, then retest
      ST_NVM:
      begin
        if (nvm_done_i)
        begin
          st_d      = ST_RUN;
          // set here only, cleared by reset
          nvm_flt_d = !nvm_pass_i;
        end
      end
      ST_RUN: st_d = ST_RUN;   // left only by ignition reset
      default: st_d = ST_MEM;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q      <= ST_MEM;
      nvm_flt_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      nvm_flt_q <= nvm_flt_d;
    end
  end

  logic run;  // normal functions allowed
  assign run           = (st_q == ST_RUN);
  assign mem_test_o    = (st_q == ST_MEM);
  assign nvm_test_o    = (st_q == ST_NVM);
  assign core_reset_o  = (st_q == ST_RST);
  assign func_en_o     = run;
  assign default_cal_o = nvm_flt_q;

  //////////////////////////////////////////////////////////////////////
  // raw fault conditions
  logic [NCH-1:0] raw;  // unfiltered fault per channel

  always_comb
  begin
    // motor off checks; energized adds line short
    raw[CH_MOT]  = motor_hl_gnd_i | motor_lh_gnd_i | motor_open_i
                 | (motor_on_i & motor_lines_i);
    raw[CH_ENC]  = !ENC_VALID[enc_code_i] | (|enc_gnd_i);
    raw[CH_FRNT] = front_flt_i;
    raw[CH_REAR] = rear_flt_i;
    raw[CH_COIL] = coil_open_i | coil_gnd_i;
  end

  //////////////////////////////////////////////////////////////////////
  // qualification and recovery filters
  logic [MS_W-1:0] cnt_q [NCH];
  logic [MS_W-1:0] cnt_d [NCH];
  logic [NCH-1:0]  conf_q, conf_d;  // confirmed fault per channel

  // one counter per channel serves both directions: it times the
  // disagreement between the raw and confirmed state
  always_comb
  begin
    conf_d = conf_q;
    for (int i = 0; i < NCH; i++)
    begin
      cnt_d[i] = cnt_q[i];
      if (!run)
      begin
        conf_d[i] = 1'b0;
        cnt_d[i]  = '0;
      end
      else if (raw[i] == conf_q[i])
        cnt_d[i] = '0;
      else if (tick_q)
      begin
        if (cnt_q[i] == lim_of(i) - 10'd1)
        begin
          conf_d[i] = raw[i];
          cnt_d[i]  = '0;
        end
        else
          cnt_d[i] = cnt_q[i] + 10'd1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conf_q <= '0;
      for (int i = 0; i < NCH; i++)
        cnt_q[i] <= '0;
    end
    else
    begin
      conf_q <= conf_d;
      for (int i = 0; i < NCH; i++)
        cnt_q[i] <= cnt_d[i];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // latched degraded modes
  logic mlatch_q, mlatch_d;  // energized motor fault
  logic sblk_q, sblk_d;      // speed-fault shift block
  logic high_q, high_d;      // forced move toward high
  logic lforce_q, lforce_d;  // low-range duty force
  logic me_rise, spd;        // new motor/encoder fault, speed fault

  assign me_rise = (conf_d[CH_MOT] & !conf_q[CH_MOT])
                 | (conf_d[CH_ENC] & !conf_q[CH_ENC]);
  assign spd     = conf_q[CH_FRNT] | conf_q[CH_REAR];

  always_comb
  begin
    mlatch_d = mlatch_q | (conf_d[CH_MOT] & !conf_q[CH_MOT] & motor_on_i);
    sblk_d   = sblk_q | spd;
    high_d   = high_q
             | (conf_d[CH_ENC] & !conf_q[CH_ENC] & shift_busy_i
                & !ENC_VALID[enc_code_i]);
    lforce_d = low_range_i & (lforce_q | spd);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mlatch_q <= 1'b0;
      sblk_q   <= 1'b0;
      high_q   <= 1'b0;
      lforce_q <= 1'b0;
    end
    else
    begin
      mlatch_q <= mlatch_d;
      sblk_q   <= sblk_d;
      high_q   <= high_d;
      lforce_q <= lforce_d;
    end
  end

  logic me_flt;  // motor or encoder fault in force
  assign me_flt = conf_q[CH_MOT] | conf_q[CH_ENC] | mlatch_q;

  assign shift_allow_o  = run & !me_flt & !sblk_q & !high_q;
  assign shift_cancel_o = me_rise & shift_pend_i & !shift_busy_i;
  assign drive_high_o   = high_q;
  // touch-off source, 3 = zero speed
  assign touch_sel_o    = {conf_q[CH_REAR], conf_q[CH_FRNT]};
  assign slip_off_o     = spd & !low_range_i;
  assign duty_force_o   = lforce_q;
  assign duty_max_o     = DUTY_MAX_PCT;
  assign torque_stop_o  = conf_q[CH_COIL];
  // lamp stays dark until memory test passes
  assign drive_fault_lamp_o = run & (nvm_flt_q | me_flt | spd
                                     | conf_q[CH_COIL]);

  //////////////////////////////////////////////////////////////////////
  // trouble code store
  logic [4:0] code_q, code_d;  // stored first-seen codes
  logic       wr_q, wr_d;      // write strobe to store
  logic       erase;           // erase from link or software

  always_comb
  begin
    code_d = code_q;
    wr_d   = 1'b0;
    if (st_q == ST_NVM && nvm_done_i && nvm_pass_i)
      code_d = nvm_codes_i;
    else if (erase)
    begin
      code_d = (run && !nvm_flt_q) ? (conf_d & ~conf_q) : 5'd0;
      wr_d   = 1'b1;
    end
    // first detection writes code; not on fault
    else if (run && !nvm_flt_q && |(conf_d & ~conf_q & ~code_q))
    begin
      code_d = code_q | (conf_d & ~conf_q);
      wr_d   = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      code_q <= '0;
      wr_q   <= 1'b0;
    end
    else
    begin
      code_q <= code_d;
      wr_q   <= wr_d;
    end
  end

  assign nvm_wr_o    = wr_q;
  assign nvm_wdata_o = code_q;

  //////////////////////////////////////////////////////////////////////
  // k-line link: one command byte in, one code byte out
  dfm_lk_e     lk_q, lk_d;      // link state
  logic [13:0] bc_q, bc_d;      // bit timer
  logic [3:0]  bi_q, bi_d;      // bit index
  logic [9:0]  sh_q, sh_d;      // shift register
  logic        lk_er;           // erase command seen
  logic        link_en_q, link_en_d;
  logic        sw_er;           // software erase strobe

  always_comb
  begin
    lk_d  = lk_q;
    bc_d  = bc_q;
    bi_d  = bi_q;
    sh_d  = sh_q;
    lk_er = 1'b0;
    case (lk_q)
      LK_IDLE:
      begin
        // start edge: sample at bit centres
        if (link_en_q && run && !kline_i)
        begin
          lk_d = LK_RX;
          bc_d = 14'(BIT_CYC / 2);
          bi_d = 4'd0;
        end
      end
      LK_RX:
      begin
        if (bc_q != 14'd0)
          bc_d = bc_q - 14'd1;
        else
        begin
          bc_d = 14'(BIT_CYC - 1);
          bi_d = bi_q + 4'd1;
          sh_d = {kline_i, sh_q[9:1]};
          if (bi_q == 4'd0 && kline_i)
            lk_d = LK_IDLE;    // glitch, not a start bit
          else if (bi_q == 4'd9)
          begin
            // answer read with codes, erase with zero
            lk_d  = LK_IDLE;
            bi_d  = 4'd0;
            lk_er = kline_i && sh_q[9:2] == CMD_ERASE;
            if (kline_i && (sh_q[9:2] == CMD_READ || lk_er))
            begin
              lk_d = LK_TX;
              sh_d = {1'b1, 3'b000, lk_er ? 5'd0 : code_q, 1'b0};
            end
          end
        end
      end
      LK_TX:
      begin
        if (bc_q != 14'd0)
          bc_d = bc_q - 14'd1;
        else
        begin
          bc_d = 14'(BIT_CYC - 1);
          bi_d = bi_q + 4'd1;
          sh_d = {1'b1, sh_q[9:1]};
          if (bi_q == 4'd9)
            lk_d = LK_IDLE;
        end
      end
      default: lk_d = LK_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lk_q <= LK_IDLE;
      bc_q <= '0;
      bi_q <= '0;
      sh_q <= '1;
    end
    else
    begin
      lk_q <= lk_d;
      bc_q <= bc_d;
      bi_q <= bi_d;
      sh_q <= sh_d;
    end
  end

  // open drain: only ever pulls low
  assign kline_o    = 1'b0;
  assign kline_oe_o = (lk_q == LK_TX) & !sh_q[0];
  assign erase      = lk_er | sw_er;

  //////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state, unmapped reads zero
  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic        wr_hit;

  assign wr_hit = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0]
                & (wb_adr_i == REG_CTRL);
  assign sw_er  = wr_hit & wb_dat_i[CTRL_ERASE];

  always_comb
  begin
    ack_d     = wb_cyc_i & wb_stb_i & !ack_q;
    link_en_d = wr_hit ? wb_dat_i[CTRL_LINK] : link_en_q;
    case (wb_adr_i)
      REG_CTRL: rd_d = {31'd0, link_en_q};
      REG_STAT: rd_d = {12'd0, st_q, 6'd0, lforce_q, high_q, sblk_q,
                        mlatch_q, nvm_flt_q, conf_q};
      REG_CODE: rd_d = {27'd0, code_q};
      default:  rd_d = 32'd0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q     <= 1'b0;
      rd_q      <= '0;
      link_en_q <= CTRL_LINK_RST;
    end
    else
    begin
      ack_q     <= ack_d;
      rd_q      <= rd_d;
      link_en_q <= link_en_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  AST_LAMP_DARK:
    assert property (!run |-> !drive_fault_lamp_o && !func_en_o)
    else $error("lamp or functions active before memory pass");
  AST_NVM_LAMP:
    assert property (run && nvm_flt_q |-> drive_fault_lamp_o)
    else $error("calibration fault without lamp");
  AST_NO_RECORD:
    assert property (nvm_flt_q && !erase |=> !nvm_wr_o)
    else $error("code written with calibration fault");
  AST_NVM_HELD:
    assert property (nvm_flt_q |=> nvm_flt_q)
    else $error("calibration fault cleared");
  AST_MOT_QUAL:
    assert property ($rose(conf_q[CH_MOT]) |->
                     $past(cnt_q[CH_MOT]) == 10'd999 && $past(tick_q))
    else $error("motor fault confirmed early");
  AST_SHIFT_OFF:
    assert property (me_flt || sblk_q |-> !shift_allow_o)
    else $error("shift allowed with fault");
  AST_MOT_LATCH:
    assert property (mlatch_q |=> mlatch_q && drive_fault_lamp_o)
    else $error("energized motor fault released");
  AST_LOW_DUTY:
    assert property (spd && low_range_i |=>
                     duty_force_o && duty_max_o == 7'd88)
    else $error("low range duty not forced");
  AST_COIL:
    assert property ($rose(conf_q[CH_COIL]) |->
                     $past(cnt_q[CH_COIL]) == 10'd799 && torque_stop_o)
    else $error("coil fault timing wrong");
  AST_RESTART:
    assert property (run && raw == conf_q |=> cnt_q[CH_ENC] == '0)
    else $error("filter kept count after drop out");
  AST_ACK:
    assert property (wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
    else $error("bus answer timing wrong");

endmodule

//--- rtl/dfm_pkg.sv
// constants for the drivetrain fault monitor
package dfm_pkg;
  // clock and time base
  localparam int CLK_NS   = 10;
  localparam int TICK_NS  = 1_000_000;  // one time-base tick = 1 ms
  localparam int KLINE_BD = 10400;      // link rate in baud
  localparam int CLK_HZ   = 1_000_000_000 / CLK_NS;
  // qualification / recovery times in ms
  localparam int MS_W = 10;
  localparam logic [MS_W-1:0] MOTOR_MS = 10'd1000;
  localparam logic [MS_W-1:0] SPEED_MS = 10'd500;
  localparam logic [MS_W-1:0] COIL_MS  = 10'd800;
  // fault channels
  localparam int NCH     = 5;
  localparam int CH_MOT  = 0;
  localparam int CH_ENC  = 1;
  localparam int CH_FRNT = 2;
  localparam int CH_REAR = 3;
  localparam int CH_COIL = 4;
  // encoder: set bit = valid code (nine codes)
  localparam logic [15:0] ENC_VALID = 16'h01FF;
  // degraded low-range clutch duty in percent
  localparam logic [6:0] DUTY_MAX_PCT = 7'd88;
  // link command bytes
  localparam logic [7:0] CMD_READ  = 8'h11;
  localparam logic [7:0] CMD_ERASE = 8'h14;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CODE = 4'h8;
  // field positions
  localparam int CTRL_LINK  = 0;
  localparam int CTRL_ERASE = 1;
  localparam logic CTRL_LINK_RST = 1'b1;
  // self-test states
  typedef enum logic [3:0] {
    ST_MEM = 4'b0001,
    ST_RST = 4'b0010,
    ST_NVM = 4'b0100,
    ST_RUN = 4'b1000
  } dfm_st_e;
  // link states
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_RX   = 3'b010,
    LK_TX   = 3'b100
  } dfm_lk_e;
endpackage

//--- dv/dfm_partner.sv
// far-side model: program and calibration memory test engines
`timescale 1ns/1ps
module dfm_partner
  import dfm_pkg::*;
(
  // clock and ignition reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // test requests from the monitor
  input  wire logic       mem_test_i,
  input  wire logic       nvm_test_i,
  input  wire logic       core_reset_i,
  // scenario knobs from the bench
  input  wire logic [1:0] mem_fails_i,
  input  wire logic       nvm_ok_i,
  input  wire logic [4:0] codes_i,
  // test results
  output logic            mem_done_o,
  output logic            mem_pass_o,
  output logic            nvm_done_o,
  output logic            nvm_pass_o,
  output logic [4:0]      nvm_codes_o
);
  logic [3:0] dly_q;  // cycles spent in the current test
  logic [3:0] dly_d;
  logic [1:0] fail_q; // failed program memory passes so far
  logic [1:0] fail_d;

  ////////////////////////////////////////////////////////////////////////
  // next state: the delay restarts on every new test state
  always_comb
  begin
    dly_d  = (mem_test_i | nvm_test_i) & !mem_done_o ? dly_q + 4'h1 : 4'h0;
    fail_d = fail_q + {1'b0, core_reset_i};
  end

  // registers only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dly_q  <= 4'h0;
      fail_q <= 2'h0;
    end
    else
    begin
      dly_q  <= dly_d;
      fail_q <= fail_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // results are only meaningful with done; otherwise they wander so
  // that a monitor sampling too early cannot get a lucky value
  assign mem_done_o  = mem_test_i & (dly_q >= 4'h3);
  assign mem_pass_o  = mem_done_o ? (fail_q == mem_fails_i) : dly_q[0];
  assign nvm_done_o  = nvm_test_i & (dly_q >= 4'h5);
  assign nvm_pass_o  = nvm_done_o ? nvm_ok_i : dly_q[0];
  assign nvm_codes_o = nvm_done_o ? codes_i : ~codes_i;
endmodule

//--- dv/dfm_top_tb.sv
// self-checking bench for the drivetrain fault monitor
`timescale 1ns/1ps
module dfm_top_tb
  import dfm_pkg::*;
;
  localparam int TK = 4;  // clocks per tick, shortened for the run
  localparam int BC = 16; // clocks per link bit
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o, mem_done_i, mem_pass_i, nvm_done_i, nvm_pass_i;
  logic [4:0] nvm_codes_i, nvm_wdata_o;
  logic mem_test_o, nvm_test_o, core_reset_o, func_en_o, default_cal_o;
  logic nvm_wr_o, motor_on_i = 1'b0, motor_lines_i = 1'b0;
  logic motor_hl_gnd_i = 1'b0, motor_lh_gnd_i = 1'b0, motor_open_i = 1'b0;
  logic [3:0] enc_code_i = 4'h0, enc_gnd_i = 4'h0;
  logic front_flt_i = 1'b0, rear_flt_i = 1'b0;
  logic coil_open_i = 1'b0, coil_gnd_i = 1'b0, low_range_i = 1'b0;
  logic shift_pend_i = 1'b0, shift_busy_i = 1'b0;
  logic drive_fault_lamp_o, shift_allow_o, shift_cancel_o, drive_high_o;
  logic [1:0] touch_sel_o;
  logic [6:0] duty_max_o;
  logic slip_off_o, duty_force_o, torque_stop_o, kline_i, kline_o;
  logic kline_oe_o, tst_q = 1'b1;   // tester line drive, idle high
  logic [1:0] fails_q = 2'h2;       // failed memory passes to give
  logic nvm_ok_q = 1'b1;
  logic [4:0] codes_q = 5'h00;      // codes held in calibration memory
  int n_errors = 0, cmp_count = 0;
  int wr_cnt = 0, cancel_cnt = 0, rst_cnt = 0, dark_bad = 0;
  logic [4:0] wr_last = 5'h00;

  // open-drain line with pull-up: low if either side pulls
  assign kline_i = tst_q & ~kline_oe_o;

  dfm_top #(.TICK_CYC(TK), .BIT_CYC(BC)) uut (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .mem_done_i, .mem_pass_i, .nvm_done_i, .nvm_pass_i,
    .nvm_codes_i, .mem_test_o, .nvm_test_o, .core_reset_o, .func_en_o,
    .default_cal_o, .nvm_wr_o, .nvm_wdata_o, .motor_on_i, .motor_hl_gnd_i,
    .motor_lh_gnd_i, .motor_lines_i, .motor_open_i, .enc_code_i,
    .enc_gnd_i, .front_flt_i, .rear_flt_i, .coil_open_i, .coil_gnd_i,
    .low_range_i, .shift_pend_i, .shift_busy_i, .drive_fault_lamp_o,
    .shift_allow_o, .shift_cancel_o, .drive_high_o, .touch_sel_o,
    .slip_off_o, .duty_force_o, .duty_max_o, .torque_stop_o, .kline_i,
    .kline_o, .kline_oe_o);

  dfm_partner mdl (.clk_i, .rst_i, .mem_test_i(mem_test_o),
    .nvm_test_i(nvm_test_o), .core_reset_i(core_reset_o),
    .mem_fails_i(fails_q), .nvm_ok_i(nvm_ok_q), .codes_i(codes_q),
    .mem_done_o(mem_done_i), .mem_pass_o(mem_pass_i),
    .nvm_done_o(nvm_done_i), .nvm_pass_o(nvm_pass_i),
    .nvm_codes_o(nvm_codes_i));

  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////
  // event monitors: pulses are counted at the edge that sees them
  always @(posedge clk_i)
  begin
    if (nvm_wr_o === 1'b1)
    begin
      wr_cnt++;
      wr_last = nvm_wdata_o;
    end
    if (shift_cancel_o === 1'b1)
      cancel_cnt++;
    if (core_reset_o === 1'b1)
      rst_cnt++;
    if (mem_test_o === 1'b1 && (drive_fault_lamp_o | func_en_o) !== 1'b0)
      dark_bad++;
  end

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n * TK) @(posedge clk_i);
    #1;
  endtask

  // classic single cycle; the answer is awaited, never assumed
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20)
      n_errors++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (func_en_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    #1;
  endtask

  // tester frame: start, eight data bits lsb first, stop
  task automatic kl_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i);
      tst_q <= f[i];
      repeat (BC - 1) @(posedge clk_i);
    end
  endtask

  task automatic kl_recv(output logic [7:0] b);
    int n;
    n = 0;
    while (kline_i !== 1'b0 && n < 40 * BC)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40 * BC)
      n_errors++;
    repeat (BC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BC) @(posedge clk_i);
      b[i] = kline_i;
    end
    repeat (2 * BC) @(posedge clk_i);
  endtask

  task automatic fin(input string s);
    $display("test %s done, %0d mismatches so far", s, n_errors);
  endtask

  task automatic close_out;
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // a hang counts as a mismatch and ends the run in the same place
  initial
  begin
    repeat (80000) @(posedge clk_i);
    n_errors++;
    close_out;
  end

  initial
  begin
    logic [31:0] q;
    logic [7:0] b;
    logic [4:0] cm;  // expected stored code mask
    int n;
    void'($urandom(32'h92b3_4d71));
    codes_q    = {3'($urandom_range(0, 7)), 2'b00};
    enc_code_i = 4'($urandom_range(0, 8));
    cm = codes_q;
    repeat (20) @(posedge clk_i);
    #1;
    chk(mem_test_o, 1'b1);
    chk(duty_max_o, DUTY_MAX_PCT);
    @(posedge clk_i);
    rst_i <= 1'b0;
    wait_run;
    chk(rst_cnt, 2);
    chk(dark_bad, 0);
    wb(1'b0, REG_STAT, '0, q);
    chk(q[19:16], 4'h8);
    wb(1'b0, REG_CODE, '0, q);
    chk(q[4:0], cm);
    wb(1'b0, 4'hc, '0, q);
    chk(q, '0);
    fin("selftest");
    // motor fault, de-energized, interrupted once then held
    n = $urandom_range(0, 2);
    @(posedge clk_i);
    {motor_hl_gnd_i, motor_lh_gnd_i, motor_open_i} <= 3'b001 << n;
    shift_pend_i <= 1'b1;
    tk(500);
    @(posedge clk_i);
    {motor_hl_gnd_i, motor_lh_gnd_i, motor_open_i} <= 3'b000;
    tk(2);
    @(posedge clk_i);
    {motor_hl_gnd_i, motor_lh_gnd_i, motor_open_i} <= 3'b001 << n;
    tk(995);
    chk(drive_fault_lamp_o, 1'b0);
    tk(10);
    chk(drive_fault_lamp_o, 1'b1);
    chk(shift_allow_o, 1'b0);
    chk(cancel_cnt > 0, 1'b1);
    cm = cm | 5'h01;
    chk(wr_last, cm);
    @(posedge clk_i);
    {motor_hl_gnd_i, motor_lh_gnd_i, motor_open_i} <= 3'b000;
    shift_pend_i <= 1'b0;
    tk(1005);
    chk(drive_fault_lamp_o, 1'b0);
    chk(shift_allow_o, 1'b1);
    fin("motor");
    // tester reads then erases the stored codes
    kl_send(CMD_READ);
    kl_recv(b);
    chk(b, {3'b000, cm});
    kl_send(CMD_ERASE);
    kl_recv(b);
    chk(b, 8'h00);
    chk(kline_o, 1'b0);
    wb(1'b0, REG_CODE, '0, q);
    chk(q[4:0], 5'h00);
    fin("link");
    // grounded encoder line, then recovery
    @(posedge clk_i);
    enc_gnd_i <= 4'h1 << $urandom_range(0, 3);
    tk(1005);
    wb(1'b0, REG_STAT, '0, q);
    chk(q[1], 1'b1);
    enc_gnd_i <= 4'h0;
    tk(1005);
    chk(shift_allow_o, 1'b1);
    fin("encoder");
    // one then both speed sensors in high range, then low range
    @(posedge clk_i);
    front_flt_i <= 1'b1;
    tk(505);
    chk({drive_fault_lamp_o, slip_off_o, touch_sel_o}, 4'hd);
    @(posedge clk_i);
    rear_flt_i <= 1'b1;
    tk(505);
    chk(touch_sel_o, 2'b11);
    @(posedge clk_i);
    low_range_i <= 1'b1;
    tk(1);
    chk({duty_force_o, duty_max_o}, {1'b1, 7'd88});
    @(posedge clk_i);
    {front_flt_i, rear_flt_i, low_range_i} <= 3'b000;
    tk(505);
    chk(drive_fault_lamp_o, 1'b0);
    chk(shift_allow_o, 1'b0);
    fin("speed");
    // invalid code confirmed mid-shift
    @(posedge clk_i);
    shift_busy_i <= 1'b1;
    enc_code_i   <= 4'($urandom_range(9, 15));
    tk(1005);
    chk(drive_high_o, 1'b1);
    fin("midshift");
    @(posedge clk_i);
    shift_busy_i <= 1'b0;
    enc_code_i   <= 4'h0;
    // clutch coil, open or grounded
    {coil_gnd_i, coil_open_i} <= 2'($urandom_range(1, 3));
    tk(795);
    chk(torque_stop_o, 1'b0);
    tk(10);
    chk({torque_stop_o, drive_fault_lamp_o}, 2'b11);
    @(posedge clk_i);
    {coil_gnd_i, coil_open_i} <= 2'b00;
    tk(805);
    chk({torque_stop_o, drive_fault_lamp_o}, 2'b00);
    fin("coil");
    // lines shorted together while energized stays latched
    @(posedge clk_i);
    {motor_on_i, motor_lines_i} <= 2'b11;
    tk(1005);
    wb(1'b0, REG_STAT, '0, q);
    chk(q[6], 1'b1);
    {motor_on_i, motor_lines_i} <= 2'b00;
    tk(1005);
    chk(drive_fault_lamp_o, 1'b1);
    fin("energized");
    // software erase over the bus
    wb(1'b1, REG_CTRL, 32'h0000_0003, q);
    wb(1'b0, REG_CODE, '0, q);
    chk(q, 32'h0000_0000);
    wb(1'b0, REG_CTRL, '0, q);
    chk(q, 32'h0000_0001);
    chk(wr_last, 5'h00);
    // ignition cycle with a bad calibration memory
    rst_i    <= 1'b1;
    fails_q  <= 2'h0;
    nvm_ok_q <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_run;
    chk({default_cal_o, drive_fault_lamp_o}, 2'b11);
    n = wr_cnt;
    @(posedge clk_i);
    front_flt_i <= 1'b1;
    tk(505);
    chk(wr_cnt, n);
    @(posedge clk_i);
    front_flt_i <= 1'b0;
    tk(505);
    chk(default_cal_o, 1'b1);
    fin("calibration");
    close_out;
  end
endmodule
